// ==== verilog/bridge_access_status_irq.sv ====
// bridge access status, secondary interrupt flags and cascade summary
`timescale 1ns/1ps
`default_nettype none

module bridge_access_status_irq #(
	parameter logic [15:0] TIMEOUT_MAX_CYCLES = bridge_status_pkg::TIMEOUT_MAX_DEFAULT
) (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	// control link pins, asynchronous to ref_clk_in
	input  wire logic        link_clk_in,
	input  wire logic        cmd_req_in,
	input  wire logic        cmd_write_in,
	input  wire logic [15:0] cmd_addr_in,
	input  wire logic [7:0]  cmd_wdata_in,
	// command response
	output logic             rsp_valid_out,
	output logic [1:0]       rsp_code_out,
	output logic [7:0]       rsp_data_out,
	// frame events from the link manager
	input  wire logic        sync_lost_in,
	input  wire logic        internal_reset_in,
	// internal peripheral bus master
	output logic             pbus_req_out,
	output logic             pbus_write_out,
	output logic [15:0]      pbus_addr_out,
	output logic [7:0]       pbus_wdata_out,
	input  wire logic        pbus_ready_in,
	input  wire logic [7:0]  pbus_rdata_in,
	// cascaded interrupt
	output logic             secondary_irq_summary_out
);

	localparam int LINK_W = 27;

	logic [LINK_W-1:0]               meta_q;
	logic [LINK_W-1:0]               stable_q;
	logic                            clk_prev_q;
	bridge_status_pkg::bridge_state_t state_q;
	logic [7:0]                      win_cnt_q;
	logic [15:0]                     to_cnt_q;
	logic                            pbus_req_q;
	logic                            pbus_write_q;
	logic [15:0]                     pbus_addr_q;
	logic [7:0]                      pbus_wdata_q;
	logic [7:0]                      flags_q;
	logic [7:0]                      enables_q;
	logic [1:0]                      late_policy_q;
	logic [3:0]                      timeout_cfg_q;
	logic                            last_late_q;
	logic                            late_seen_q;
	logic                            done_q;
	logic                            rdy_q;
	logic [7:0]                      rdata_q;
	logic [15:0]                     last_addr_q;
	logic                            rsp_valid_q;
	logic [1:0]                      rsp_code_q;
	logic [7:0]                      rsp_data_q;
	logic                            irq_q;

	logic        s_req;
	logic        s_write;
	logic [15:0] s_addr;
	logic [7:0]  s_wdata;
	logic        cmd_take;
	logic        is_bridged;
	logic        hit_held;
	logic        bridge_start;
	logic        pbus_done;
	logic        timeout_hit;
	logic        win_expire;
	logic        late_evt;
	logic        reg_wr;
	logic [7:0]  w1c_mask;
	logic [7:0]  reg_rdata;
	logic        reg_mapped;
	logic [7:0]  access_state;
	logic [15:0] to_limit;
	logic        summary_d;

	// two flops on every link pin; edges are found only on the second stage
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q     <= '0;
			stable_q   <= '0;
			clk_prev_q <= 1'b0;
		end else begin
			meta_q     <= {link_clk_in, cmd_req_in, cmd_write_in, cmd_addr_in, cmd_wdata_in};
			stable_q   <= meta_q;
			clk_prev_q <= stable_q[26];
		end
	end

	assign s_req      = stable_q[25];
	assign s_write    = stable_q[24];
	assign s_addr     = stable_q[23:8];
	assign s_wdata    = stable_q[7:0];
	assign cmd_take   = stable_q[26] && !clk_prev_q && s_req;
	assign is_bridged = s_addr >= bridge_status_pkg::BRIDGE_BASE;
	assign hit_held   = !s_write && rdy_q && (s_addr == last_addr_q);
	// a held-data read is served from the bridge and starts no bus access
	assign bridge_start = cmd_take && is_bridged && (state_q == bridge_status_pkg::ST_IDLE)
		&& !hit_held;

	assign to_limit    = bridge_status_pkg::timeout_limit(timeout_cfg_q[2:0], TIMEOUT_MAX_CYCLES);
	assign pbus_done   = pbus_req_q && pbus_ready_in;
	assign timeout_hit = pbus_req_q && !pbus_ready_in
		&& !timeout_cfg_q[bridge_status_pkg::TO_DISABLE_BIT]
		&& (to_cnt_q >= to_limit - 16'h0001);
	assign win_expire  = (state_q == bridge_status_pkg::ST_WAIT_DIRECT) && !pbus_ready_in
		&& !timeout_hit && (win_cnt_q == bridge_status_pkg::DIRECT_WAIT_CYCLES - 8'h01);
	assign late_evt    = last_late_q && !late_seen_q;
	assign reg_wr      = cmd_take && s_write && !is_bridged;
	assign w1c_mask    = (reg_wr && s_addr == bridge_status_pkg::OFS_SEC_FLAGS)
		? (s_wdata & bridge_status_pkg::SEC_IMPL_MASK) : 8'h00;
	assign access_state = {4'h0, last_late_q, pbus_req_q, done_q, rdy_q};
	assign summary_d   = |(flags_q & enables_q & bridge_status_pkg::SEC_IMPL_MASK);

	always_comb begin
		reg_rdata  = 8'h00;
		reg_mapped = 1'b1;
		if (s_addr == bridge_status_pkg::OFS_PRIMARY_FLAGS) begin
			reg_rdata[bridge_status_pkg::PRIMARY_CASCADE_BIT] = irq_q;
		end else if (s_addr == bridge_status_pkg::OFS_SEC_FLAGS) begin
			reg_rdata = flags_q;
		end else if (s_addr == bridge_status_pkg::OFS_SEC_ENABLES) begin
			reg_rdata = enables_q;
		end else if (s_addr == bridge_status_pkg::OFS_ACCESS_STATE) begin
			reg_rdata = access_state;
		end else if (s_addr == bridge_status_pkg::OFS_LATE_POLICY) begin
			reg_rdata = {6'h00, late_policy_q};
		end else if (s_addr == bridge_status_pkg::OFS_TIMEOUT_CFG) begin
			reg_rdata = {4'h0, timeout_cfg_q};
		end else if (s_addr == bridge_status_pkg::OFS_LAST_ADDR_LO) begin
			reg_rdata = last_addr_q[7:0];
		end else if (s_addr == bridge_status_pkg::OFS_LAST_ADDR_HI) begin
			reg_rdata = last_addr_q[15:8];
		end else if (s_addr == bridge_status_pkg::OFS_READ_DATA) begin
			reg_rdata = rdata_q;
		end else begin
			reg_mapped = 1'b0;
		end
	end

	// bridge sequencing
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= bridge_status_pkg::ST_IDLE;
		end else begin
			case (state_q)
				bridge_status_pkg::ST_IDLE: begin
					if (bridge_start) begin
						// writes are posted, so they never need the direct window
						state_q <= s_write ? bridge_status_pkg::ST_BACKGROUND
							: bridge_status_pkg::ST_WAIT_DIRECT;
					end
				end
				bridge_status_pkg::ST_WAIT_DIRECT: begin
					if (pbus_done || timeout_hit) begin
						state_q <= bridge_status_pkg::ST_IDLE;
					end else if (win_expire) begin
						state_q <= bridge_status_pkg::ST_BACKGROUND;
					end
				end
				default: begin
					if (pbus_done || timeout_hit) begin
						state_q <= bridge_status_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// window and timeout counters
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			win_cnt_q <= 8'h00;
			to_cnt_q  <= 16'h0000;
		end else begin
			if (bridge_start) begin
				win_cnt_q <= 8'h00;
				to_cnt_q  <= 16'h0000;
			end else begin
				if (state_q == bridge_status_pkg::ST_WAIT_DIRECT) begin
					win_cnt_q <= win_cnt_q + 8'h01;
				end
				if (pbus_req_q && to_cnt_q != 16'hFFFF) begin
					to_cnt_q <= to_cnt_q + 16'h0001;
				end
			end
		end
	end

	// peripheral bus request, held until ready or timeout
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pbus_req_q   <= 1'b0;
			pbus_write_q <= 1'b0;
			pbus_addr_q  <= 16'h0000;
			pbus_wdata_q <= 8'h00;
		end else if (bridge_start) begin
			pbus_req_q   <= 1'b1;
			pbus_write_q <= s_write;
			pbus_addr_q  <= s_addr;
			pbus_wdata_q <= s_wdata;
		end else if (pbus_done || timeout_hit) begin
			pbus_req_q <= 1'b0;
		end
	end

	// access status bits; completion wins over a clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_late_q <= 1'b0;
			late_seen_q <= 1'b0;
			done_q      <= 1'b0;
			rdy_q       <= 1'b0;
			rdata_q     <= 8'h00;
			last_addr_q <= 16'h0000;
		end else begin
			late_seen_q <= last_late_q;
			if (win_expire) begin
				last_late_q <= 1'b1;
			end else if (bridge_start) begin
				last_late_q <= 1'b0;
			end
			if (pbus_done) begin
				done_q <= 1'b1;
			end else if (cmd_take && is_bridged) begin
				done_q <= 1'b0;
			end
			if (pbus_done && !pbus_write_q && state_q == bridge_status_pkg::ST_BACKGROUND) begin
				rdy_q       <= 1'b1;
				rdata_q     <= pbus_rdata_in;
				last_addr_q <= pbus_addr_q;
			end else if (cmd_take && is_bridged && !s_write) begin
				rdy_q <= 1'b0;
			end
		end
	end

	// secondary flags and enables
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_q   <= bridge_status_pkg::SEC_FLAGS_RST;
			enables_q <= bridge_status_pkg::SEC_ENABLES_RST;
		end else begin
			// sync loss is not a reset for the flags, and a set beats a one-write
			flags_q <= flags_q & ~w1c_mask;
			if (late_evt) begin
				flags_q[bridge_status_pkg::FLAG_LATE_BIT] <= 1'b1;
			end
			if (timeout_hit) begin
				flags_q[bridge_status_pkg::FLAG_TIMEOUT_BIT] <= 1'b1;
			end
			if (reg_wr && s_addr == bridge_status_pkg::OFS_SEC_ENABLES) begin
				enables_q <= s_wdata & bridge_status_pkg::SEC_IMPL_MASK;
			end
			if (sync_lost_in || internal_reset_in) begin
				enables_q[bridge_status_pkg::FLAG_LATE_BIT] <= 1'b0;
			end
		end
	end

	// bridge policy registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			late_policy_q <= bridge_status_pkg::LATE_POLICY_RST;
			timeout_cfg_q <= bridge_status_pkg::TIMEOUT_CFG_RST;
		end else if (reg_wr) begin
			if (s_addr == bridge_status_pkg::OFS_LATE_POLICY) begin
				late_policy_q <= s_wdata[1:0];
			end else if (s_addr == bridge_status_pkg::OFS_TIMEOUT_CFG) begin
				timeout_cfg_q <= s_wdata[3:0];
			end
		end
	end

	// responses; a command landing on the window's last cycle is dropped
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rsp_valid_q <= 1'b0;
			rsp_code_q  <= bridge_status_pkg::RSP_IGNORED;
			rsp_data_q  <= 8'h00;
			irq_q       <= 1'b0;
		end else begin
			irq_q       <= summary_d;
			rsp_valid_q <= 1'b0;
			if (win_expire) begin
				rsp_valid_q <= 1'b1;
				rsp_data_q  <= 8'h00;
				// the reserved policy code answers as a failure
				rsp_code_q  <= (late_policy_q == 2'h3) ? bridge_status_pkg::RSP_FAIL
					: late_policy_q;
			end else if (state_q == bridge_status_pkg::ST_WAIT_DIRECT && pbus_done) begin
				rsp_valid_q <= 1'b1;
				rsp_code_q  <= bridge_status_pkg::RSP_OK;
				rsp_data_q  <= pbus_rdata_in;
			end else if (state_q == bridge_status_pkg::ST_WAIT_DIRECT && timeout_hit) begin
				rsp_valid_q <= 1'b1;
				rsp_code_q  <= bridge_status_pkg::RSP_FAIL;
				rsp_data_q  <= 8'h00;
			end else if (cmd_take) begin
				if (!is_bridged) begin
					rsp_valid_q <= 1'b1;
					rsp_code_q  <= reg_mapped ? bridge_status_pkg::RSP_OK
						: bridge_status_pkg::RSP_IGNORED;
					rsp_data_q  <= s_write ? 8'h00 : reg_rdata;
				end else if (state_q != bridge_status_pkg::ST_IDLE) begin
					rsp_valid_q <= 1'b1;
					rsp_code_q  <= bridge_status_pkg::RSP_FAIL;
					rsp_data_q  <= 8'h00;
				end else if (hit_held || s_write) begin
					rsp_valid_q <= 1'b1;
					rsp_code_q  <= bridge_status_pkg::RSP_OK;
					rsp_data_q  <= hit_held ? rdata_q : 8'h00;
				end
			end
		end
	end

	assign rsp_valid_out             = rsp_valid_q;
	assign rsp_code_out              = rsp_code_q;
	assign rsp_data_out              = rsp_data_q;
	assign pbus_req_out              = pbus_req_q;
	assign pbus_write_out            = pbus_write_q;
	assign pbus_addr_out             = pbus_addr_q;
	assign pbus_wdata_out            = pbus_wdata_q;
	assign secondary_irq_summary_out = irq_q;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_read_start;
		bridge_start && !s_write;
	endsequence
	sequence s_answer;
		rsp_valid_q;
	endsequence

	property p_late_flag;
		$rose(last_late_q) |=> flags_q[2];
	endproperty
	a_late_flag: assert property (p_late_flag) else $error("late flag not set");

	property p_timeout_flag;
		timeout_hit |=> flags_q[1] && !pbus_req_q;
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag missing");

	property p_w1c;
		w1c_mask[1] && !timeout_hit |=> !flags_q[1];
	endproperty
	a_w1c: assert property (p_w1c) else $error("timeout flag not cleared");

	property p_sync_loss_keeps;
		sync_lost_in && w1c_mask == 8'h00 && flags_q[2] |=> flags_q[2] && !enables_q[2];
	endproperty
	a_sync_loss_keeps: assert property (p_sync_loss_keeps) else $error("sync loss effect wrong");

	property p_summary;
		(flags_q[1] && enables_q[1]) || (flags_q[2] && enables_q[2]) |=> irq_q;
	endproperty
	a_summary: assert property (p_summary) else $error("summary not raised");

	property p_disabled;
		timeout_cfg_q[3] |=> !$rose(flags_q[1]);
	endproperty
	a_disabled: assert property (p_disabled) else $error("timeout while disabled");

	property p_busy;
		bridge_start |=> access_state[2] && state_q != bridge_status_pkg::ST_IDLE
			&& pbus_addr_q == $past(s_addr);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit low during access");

	property p_rdy_clear;
		cmd_take && is_bridged && !s_write && !pbus_done |=> !rdy_q && !done_q;
	endproperty
	a_rdy_clear: assert property (p_rdy_clear) else $error("ready or done not cleared");

	property p_direct_answer;
		s_read_start |-> ##[1:6] s_answer;
	endproperty
	a_direct_answer: assert property (p_direct_answer) else $error("read not answered");

	property p_link_regs;
		cmd_take && !is_bridged && state_q == bridge_status_pkg::ST_IDLE
			|=> $stable(done_q) && $stable(rdy_q) && $stable(last_late_q);
	endproperty
	a_link_regs: assert property (p_link_regs) else $error("status moved on link access");

endmodule

`default_nettype wire

// ==== shared/bridge_status_pkg.sv ====
// constants and types shared by the bridge status and interrupt block
package bridge_status_pkg;

	// address split between link registers and the bridged peripheral bus
	localparam logic [15:0] BRIDGE_BASE       = 16'h1000;

	// register offsets on the control link
	localparam logic [15:0] OFS_PRIMARY_FLAGS = 16'h00C0;
	localparam logic [15:0] OFS_SEC_FLAGS     = 16'h00C2;
	localparam logic [15:0] OFS_SEC_ENABLES   = 16'h00C3;
	localparam logic [15:0] OFS_ACCESS_STATE  = 16'h00D0;
	localparam logic [15:0] OFS_LATE_POLICY   = 16'h00D1;
	localparam logic [15:0] OFS_TIMEOUT_CFG   = 16'h00D2;
	localparam logic [15:0] OFS_LAST_ADDR_LO  = 16'h00D4;
	localparam logic [15:0] OFS_LAST_ADDR_HI  = 16'h00D5;
	localparam logic [15:0] OFS_READ_DATA     = 16'h00D8;

	// field positions
	localparam int FLAG_TIMEOUT_BIT    = 1;
	localparam int FLAG_LATE_BIT       = 2;
	localparam int ST_READY_BIT        = 0;
	localparam int ST_DONE_BIT         = 1;
	localparam int ST_BUSY_BIT         = 2;
	localparam int ST_LATE_BIT         = 3;
	localparam int PRIMARY_CASCADE_BIT = 7;
	localparam int TO_DISABLE_BIT      = 3;
	localparam logic [7:0] SEC_IMPL_MASK = 8'h06;

	// values after reset
	localparam logic [7:0] SEC_FLAGS_RST   = 8'h00;
	localparam logic [7:0] SEC_ENABLES_RST = 8'h00;
	localparam logic [1:0] LATE_POLICY_RST = 2'h1;
	localparam logic [3:0] TIMEOUT_CFG_RST = 4'h0;

	// response codes returned with a command
	localparam logic [1:0] RSP_IGNORED = 2'h0;
	localparam logic [1:0] RSP_OK      = 2'h1;
	localparam logic [1:0] RSP_FAIL    = 2'h2;

	// cycle counts
	localparam logic [7:0]  DIRECT_WAIT_CYCLES  = 8'h04;
	localparam logic [15:0] TIMEOUT_MAX_DEFAULT = 16'hFFFF;
	localparam logic [15:0] TO_COUNT_0 = 16'h0008;
	localparam logic [15:0] TO_COUNT_1 = 16'h0010;
	localparam logic [15:0] TO_COUNT_2 = 16'h0020;
	localparam logic [15:0] TO_COUNT_3 = 16'h0040;
	localparam logic [15:0] TO_COUNT_4 = 16'h0080;
	localparam logic [15:0] TO_COUNT_5 = 16'h0100;
	localparam logic [15:0] TO_COUNT_6 = 16'h0200;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_DIRECT,
		ST_BACKGROUND
	} bridge_state_t;

	function automatic logic [15:0] timeout_limit(input logic [2:0] sel,
		input logic [15:0] max_cycles);
		case (sel)
			3'h0: return TO_COUNT_0;
			3'h1: return TO_COUNT_1;
			3'h2: return TO_COUNT_2;
			3'h3: return TO_COUNT_3;
			3'h4: return TO_COUNT_4;
			3'h5: return TO_COUNT_5;
			3'h6: return TO_COUNT_6;
			default: return max_cycles;
		endcase
	endfunction

endpackage

// ==== tb/pbus_slave_model.sv ====
// peripheral bus slave with a settable reply delay
`timescale 1ns/1ps
`default_nettype none

module pbus_slave_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// bus from the bridge
	input  wire logic        req_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  delay_in,
	output logic             ready_out,
	output logic [7:0]       rdata_out
);
	logic [7:0] cnt_q;
	logic [7:0] last_q;

	// reply after delay_in cycles of request; a dropped request aborts the count
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 8'h00;
			ready_out <= 1'b0;
		end else begin
			ready_out <= 1'b0;
			if (!req_in)
				cnt_q <= 8'h00;
			else if (!ready_out && cnt_q >= delay_in) begin
				ready_out <= 1'b1;
				cnt_q <= 8'h00;
			end else if (!ready_out)
				cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			last_q <= 8'h00;
		else if (ready_out)
			last_q <= rdata_out;
	end

	// outside the reply cycle the data lines show no stale value
	assign rdata_out = ready_out ? (addr_in[7:0] ^ 8'h5A) : ~last_q;
endmodule

`default_nettype wire

// ==== tb/bridge_access_status_irq_tb.sv ====
// self-checking bench for the bridge status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t ns: got %h expected %h", $time, (g), (e)); end end

module bridge_access_status_irq_tb;
	logic        ref_clk_in = 1'b0;
	logic        rst_n_in   = 1'b0;
	logic        link_clk   = 1'b0;
	logic        cmd_req    = 1'b0;
	logic        cmd_write  = 1'b0;
	logic [15:0] cmd_addr   = 16'h0000;
	logic [7:0]  cmd_wdata  = 8'h00;
	logic        sync_lost  = 1'b0;
	logic        int_reset  = 1'b0;
	logic [7:0]  delay      = 8'h01;
	logic        rsp_valid;
	logic        pbus_req;
	logic        pbus_write;
	logic [7:0]  pbus_wdata;
	logic        pbus_ready;
	logic        summary;
	logic [1:0]  rsp_code;
	logic [1:0]  rcode;
	logic [7:0]  rsp_data;
	logic [7:0]  pbus_rdata;
	logic [7:0]  rdata;
	logic [15:0] pbus_addr;
	logic [1:0]  pol_code [3] = '{bridge_status_pkg::RSP_IGNORED, bridge_status_pkg::RSP_OK,
		bridge_status_pkg::RSP_FAIL};
	int          failures = 0;
	int          check_count = 0;

	always #50 ref_clk_in = ~ref_clk_in;

	bridge_access_status_irq #(.TIMEOUT_MAX_CYCLES(16'h0040)) i_dut (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
		.cmd_req_in(cmd_req), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
		.cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid), .rsp_code_out(rsp_code),
		.rsp_data_out(rsp_data), .sync_lost_in(sync_lost), .internal_reset_in(int_reset),
		.pbus_req_out(pbus_req), .pbus_write_out(pbus_write), .pbus_addr_out(pbus_addr),
		.pbus_wdata_out(pbus_wdata), .pbus_ready_in(pbus_ready), .pbus_rdata_in(pbus_rdata),
		.secondary_irq_summary_out(summary)
	);

	pbus_slave_model i_slave (
		.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(pbus_req), .addr_in(pbus_addr),
		.delay_in(delay), .ready_out(pbus_ready), .rdata_out(pbus_rdata)
	);

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			#1;
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one link period per command; the link clock stands still between commands
	task automatic cmd(input logic w, input logic [15:0] a, input logic [7:0] d);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		tick(1);
		cmd_req = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		link_clk = 1'b1;
		while (n < 40 && !(got && n >= 7)) begin
			tick(1);
			n++;
			if (n == 4)
				link_clk = 1'b0;
			if (!got && rsp_valid === 1'b1) begin
				got = 1'b1;
				rcode = rsp_code;
				rdata = rsp_data;
			end
		end
		`CHK(got, 1'b1)
		// link clock low for half a period before the next command
		cmd_req = 1'b0;
		cmd_addr = ~a;
		cmd_wdata = ~d;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		cmd(1'b0, a, 8'h00);
		`CHK(rdata, e)
	endtask

	initial begin
		#500000;
		failures++;
		$display("watchdog expired");
		give_verdict();
	end

	initial begin
		tick(16);
		rst_n_in = 1'b1;
		tick(4);
		rd_chk(16'h00C2, 8'h00);
		rd_chk(16'h00C3, 8'h00);
		rd_chk(16'h00D0, 8'h00);
		rd_chk(16'h00D1, 8'h01);
		rd_chk(16'h0050, 8'h00);
		`CHK(rcode, bridge_status_pkg::RSP_IGNORED)
		$display("test reset_values done");
		// limit 64 so long reads are not cut short
		cmd(1'b1, 16'h00D2, 8'h07);
		rd_chk(16'h1234, 8'h34 ^ 8'h5A);
		`CHK(rcode, bridge_status_pkg::RSP_OK)
		rd_chk(16'h00D0, 8'h02);
		$display("test direct_read done");
		delay = 8'h1E;
		cmd(1'b0, 16'h1010, 8'h00);
		`CHK(rcode, bridge_status_pkg::RSP_OK)
		rd_chk(16'h00D0, 8'h0C);
		cmd(1'b1, 16'h2000, 8'h55);
		`CHK(rcode, bridge_status_pkg::RSP_FAIL)
		tick(40);
		rd_chk(16'h00D0, 8'h0B);
		rd_chk(16'h00C2, 8'h04);
		rd_chk(16'h00D4, 8'h10);
		rd_chk(16'h00D5, 8'h10);
		rd_chk(16'h00D8, 8'h10 ^ 8'h5A);
		`CHK(summary, 1'b0)
		cmd(1'b1, 16'h00C3, 8'h04);
		tick(2);
		`CHK(summary, 1'b1)
		rd_chk(16'h00C0, 8'h80);
		rd_chk(16'h1010, 8'h10 ^ 8'h5A);
		cmd(1'b0, 16'h00D0, 8'h00);
		`CHK(rdata & 8'h07, 8'h00)
		$display("test late_read done");
		sync_lost = 1'b1;
		tick(1);
		sync_lost = 1'b0;
		tick(2);
		`CHK(summary, 1'b0)
		rd_chk(16'h00C2, 8'h04);
		rd_chk(16'h00C3, 8'h00);
		cmd(1'b1, 16'h00C2, 8'h02);
		rd_chk(16'h00C2, 8'h04);
		cmd(1'b1, 16'h00C2, 8'h04);
		rd_chk(16'h00C2, 8'h00);
		cmd(1'b1, 16'h00C3, 8'h04);
		int_reset = 1'b1;
		tick(1);
		int_reset = 1'b0;
		rd_chk(16'h00C3, 8'h00);
		$display("test resets done");
		delay = 8'h0C;
		for (int p = 0; p < 3; p++) begin
			cmd(1'b1, 16'h00D1, 8'(p));
			cmd(1'b0, 16'h1100 + 16'(p), 8'h00);
			`CHK(rcode, pol_code[p])
			tick(20);
		end
		cmd(1'b1, 16'h00D1, 8'h01);
		delay = 8'h01;
		cmd(1'b1, 16'h2000, 8'hA5);
		`CHK({pbus_write, pbus_addr, pbus_wdata}, {1'b1, 16'h2000, 8'hA5})
		cmd(1'b0, 16'h00D0, 8'h00);
		`CHK(rdata & 8'h0E, 8'h02)
		$display("test late_policy done");
		// limit 8 against a 20 cycle reply
		cmd(1'b1, 16'h00D2, 8'h00);
		delay = 8'h14;
		cmd(1'b1, 16'h3000, 8'h11);
		tick(20);
		rd_chk(16'h00C2, 8'h06);
		`CHK(summary, 1'b0)
		cmd(1'b1, 16'h00C3, 8'h02);
		tick(2);
		`CHK(summary, 1'b1)
		cmd(1'b1, 16'h00C2, 8'h06);
		cmd(1'b1, 16'h00D2, 8'h08);
		cmd(1'b1, 16'h3000, 8'h22);
		tick(30);
		rd_chk(16'h00C2, 8'h00);
		`CHK(summary, 1'b0)
		$display("test timeout done");
		give_verdict();
	end
endmodule

`default_nettype wire
